// [rtl/image_map_pkg.sv]
// constants for the process image mapper
`default_nettype none
package image_map_pkg;
	// ----------------------------------------------------------------
	// assembly instances and frame lengths
	// ----------------------------------------------------------------
	localparam logic [7:0] IN_INST_TABLES  = 8'h64;
	localparam logic [7:0] IN_INST_PLAIN   = 8'h65;
	localparam logic [7:0] OUT_INST_TABLES = 8'h96;
	localparam logic [7:0] OUT_INST_PLAIN  = 8'h97;
	localparam logic [7:0] CFG_INST        = 8'h04;
	localparam logic [7:0] CFG_LEN         = 8'h00;
	localparam logic [5:0] LEN_SHORT       = 6'h11;
	localparam logic [5:0] LEN_LONG        = 6'h20;
	localparam logic [5:0] IMG_BYTES       = 6'h10;
	localparam logic [5:0] TBL_NUM_POS     = 6'h10;
	localparam logic [5:0] SEG_NUM_POS     = 6'h11;
	localparam logic [5:0] CNT_MAX         = 6'h3f;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK   = 8'h08;
	localparam logic [7:0] ADDR_INFO   = 8'h0c;
	localparam logic [7:0] ADDR_LED    = 8'h10;
	localparam logic [2:0] STATUS_RST  = 3'h0;
	localparam logic [2:0] MASK_RST    = 3'h0;
	localparam int ST_FRAME_OK = 0;
	localparam int ST_LEN_ERR  = 1;
	localparam int ST_TABLE    = 2;
	// ----------------------------------------------------------------
	// led status byte bit positions
	// ----------------------------------------------------------------
	localparam int LED_OUT_FAULT = 0;
	localparam int LED_IN_FAULT  = 1;
	localparam int LED_FAULT     = 2;
	localparam int LED_DIAGNOSTIC_INDICATOR      = 3;
	localparam int LED_FS_RUN    = 4;
	localparam int LED_EXCHANGE  = 5;
	localparam int LED_ST_RUN    = 6;
	localparam int LED_RSVD      = 7;
endpackage
`default_nettype wire

// [rtl/led_status_byte.sv]
// packs base unit indicator states into the led status byte
`timescale 1ns/10ps
`default_nettype none
module led_status_byte (
	input  wire logic       output_fault_indicator,
	input  wire logic       input_fault_indicator,
	input  wire logic       fault_indicator,
	input  wire logic       diagnostic_indicator,
	input  wire logic       failsafe_run_indicator,
	input  wire logic       standard_run_indicator,
	input  wire logic       exchange_active,
	output logic [7:0]      status_byte
);
	import image_map_pkg::*;
	always_comb begin
		status_byte                = 8'h00;
		status_byte[LED_OUT_FAULT] = output_fault_indicator; // [R07]
		status_byte[LED_IN_FAULT]  = input_fault_indicator; // [R07]
		status_byte[LED_FAULT]     = fault_indicator; // [R07]
		status_byte[LED_DIAGNOSTIC_INDICATOR]      = diagnostic_indicator; // [R07]
		status_byte[LED_FS_RUN]    = failsafe_run_indicator; // [R07]
		status_byte[LED_EXCHANGE]  = exchange_active; // [R08]
		status_byte[LED_ST_RUN]    = standard_run_indicator; // [R07]
		status_byte[LED_RSVD]      = 1'b0; // [R07]
	end
endmodule // led_status_byte
`default_nettype wire

// [rtl/process_image_mapper.sv]
// cyclic process image framer between fieldbus master and base unit
// Function
// [R01] each cyclic frame is exactly 17 or 32 bytes; other lengths rejected
// [R02] input 100/101 and output 150/151 instances select 32 or 17 bytes
// [R03] instance numbers are fixed; configuration instance 4 has no data
// [R04] virtual input number is eight times byte index plus bit index
// [R05] virtual output n sits in bit n mod 8 of byte n div 8
// [R06] output image carries one extra led status byte
// [R07] led bits set while indicator lit or flashing; bit 7 reads zero
// [R08] led bit 5 shows cyclic data exchange active
// [R09] master sends table and segment numbers; device returns 15 bytes
// [R10] block starts operating after reset without any command
// [R11] in the 17-byte image the led byte sits at position 16
`timescale 1ns/10ps
`default_nettype none
module process_image_mapper (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic [31:0]       reg_rdata,
	output logic              irq,
	input  wire logic         rx_valid,
	input  wire logic [7:0]   rx_data,
	input  wire logic         rx_last,
	output logic              tx_valid,
	output logic [7:0]        tx_data,
	output logic              tx_last,
	output logic [127:0]      virtual_input_n,
	input  wire logic [127:0] virtual_output_n,
	input  wire logic         output_fault_indicator,
	input  wire logic         input_fault_indicator,
	input  wire logic         fault_indicator,
	input  wire logic         diagnostic_indicator,
	input  wire logic         failsafe_run_indicator,
	input  wire logic         standard_run_indicator,
	output logic              table_req,
	output logic [7:0]        table_num,
	output logic [7:0]        segment_num,
	input  wire logic         table_ack,
	input  wire logic [119:0] table_segment
);
	import image_map_pkg::*;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_SEND = 3'b100
	} tx_state_e;

	tx_state_e      state_reg, state_next;
	logic [7:0]     in_inst_reg, in_inst_next;
	logic [7:0]     out_inst_reg, out_inst_next;
	logic [2:0]     status_reg, status_next;
	logic [2:0]     mask_reg, mask_next;
	logic [31:0]    rdata_reg, rdata_next;
	logic           irq_reg, irq_next;
	logic [5:0]     rx_cnt_reg, rx_cnt_next;
	logic [127:0]   rx_shadow_reg, rx_shadow_next;
	logic [7:0]     tbl_reg, tbl_next;
	logic [7:0]     seg_reg, seg_next;
	logic [127:0]   vin_reg, vin_next;
	logic           active_reg, active_next;
	logic [255:0]   img_reg, img_next;
	logic [5:0]     tx_cnt_reg, tx_cnt_next;
	logic [5:0]     tx_len_reg, tx_len_next;
	logic           tx_valid_reg, tx_valid_next;
	logic [7:0]     tx_data_reg, tx_data_next;
	logic           tx_last_reg, tx_last_next;
	logic           treq_reg, treq_next;
	logic [7:0]     led_byte;
	logic [5:0]     rx_len;
	logic           frame_ok;
	logic           frame_bad;
	logic [2:0]     set_bits;

	led_status_byte u_led (
		.output_fault_indicator (output_fault_indicator),
		.input_fault_indicator  (input_fault_indicator),
		.fault_indicator        (fault_indicator),
		.diagnostic_indicator   (diagnostic_indicator),
		.failsafe_run_indicator (failsafe_run_indicator),
		.standard_run_indicator (standard_run_indicator),
		.exchange_active        (active_reg),
		.status_byte            (led_byte)
	);

	// ----------------------------------------------------------------
	// receive path from the master
	// ----------------------------------------------------------------
	always_comb begin
		rx_len = (in_inst_reg == IN_INST_TABLES) ? LEN_LONG : LEN_SHORT; // [R02]
		frame_ok = rx_valid && rx_last && (rx_cnt_reg == rx_len - 6'h01); // [R01]
		frame_bad = rx_valid && rx_last && !frame_ok; // [R01]
		rx_cnt_next = rx_cnt_reg;
		rx_shadow_next = rx_shadow_reg;
		tbl_next = tbl_reg;
		seg_next = seg_reg;
		vin_next = vin_reg;
		active_next = active_reg;
		if (rx_valid) begin
			if (rx_cnt_reg < IMG_BYTES) begin
				rx_shadow_next[{rx_cnt_reg[3:0], 3'h0} +: 8] = rx_data; // [R04]
			end
			if (rx_cnt_reg == TBL_NUM_POS) begin
				tbl_next = rx_data; // [R09]
			end
			if (rx_cnt_reg == SEG_NUM_POS) begin
				seg_next = rx_data; // [R09]
			end
			// saturate so an overlong frame cannot wrap into a legal length
			if (rx_last) begin
				rx_cnt_next = 6'h00;
			end else if (rx_cnt_reg != CNT_MAX) begin
				rx_cnt_next = rx_cnt_reg + 6'h01;
			end
		end
		if (frame_ok) begin
			vin_next = rx_shadow_next; // [R04]
			active_next = 1'b1; // [R08]
		end else if (frame_bad) begin
			active_next = 1'b0; // [R08]
		end
	end

	// ----------------------------------------------------------------
	// transmit path to the master
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		img_next = img_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_len_next = tx_len_reg;
		tx_valid_next = 1'b0;
		tx_data_next = 8'h00;
		tx_last_next = 1'b0;
		treq_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// a reply already in progress keeps its image; a frame that
				// ends meanwhile updates inputs but gets no reply of its own
				if (frame_ok) begin
					img_next[127:0] = virtual_output_n; // [R05]
					img_next[135:128] = led_byte; // [R06] [R11]
					tx_cnt_next = 6'h00;
					if (out_inst_reg == OUT_INST_TABLES) begin
						tx_len_next = LEN_LONG; // [R02]
					end else begin
						tx_len_next = LEN_SHORT; // [R02]
					end
					if (out_inst_reg == OUT_INST_TABLES &&
						in_inst_reg == IN_INST_TABLES) begin
						treq_next = 1'b1; // [R09]
						state_next = ST_WAIT;
					end else begin
						state_next = ST_SEND;
					end
				end
			end
			ST_WAIT: begin
				if (table_ack) begin
					img_next[255:136] = table_segment; // [R09]
					state_next = ST_SEND;
				end
			end
			ST_SEND: begin
				tx_valid_next = 1'b1;
				tx_data_next = img_reg[{tx_cnt_reg[4:0], 3'h0} +: 8]; // [R05]
				tx_last_next = (tx_cnt_reg == tx_len_reg - 6'h01); // [R01]
				tx_cnt_next = tx_cnt_reg + 6'h01;
				if (tx_last_next) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// register port and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		in_inst_next = in_inst_reg;
		out_inst_next = out_inst_reg;
		mask_next = mask_reg;
		rdata_next = 32'h00000000;
		set_bits = 3'h0;
		set_bits[ST_FRAME_OK] = frame_ok;
		set_bits[ST_LEN_ERR] = frame_bad;
		set_bits[ST_TABLE] = (state_reg == ST_WAIT) && table_ack;
		status_next = status_reg;
		if (reg_wr) begin
			if (reg_addr == ADDR_CTRL) begin
				// only the fixed instance numbers are taken
				if (reg_wdata[7:0] == IN_INST_TABLES ||
					reg_wdata[7:0] == IN_INST_PLAIN) begin
					in_inst_next = reg_wdata[7:0]; // [R02] [R03]
				end
				if (reg_wdata[15:8] == OUT_INST_TABLES ||
					reg_wdata[15:8] == OUT_INST_PLAIN) begin
					out_inst_next = reg_wdata[15:8]; // [R02] [R03]
				end
			end else if (reg_addr == ADDR_STATUS) begin
				status_next = status_reg & ~reg_wdata[2:0];
			end else if (reg_addr == ADDR_MASK) begin
				mask_next = reg_wdata[2:0];
			end
		end
		status_next = status_next | set_bits;
		if (reg_rd) begin
			if (reg_addr == ADDR_CTRL) begin
				rdata_next = {16'h0000, out_inst_reg, in_inst_reg};
			end else if (reg_addr == ADDR_STATUS) begin
				rdata_next = {29'h00000000, status_reg};
			end else if (reg_addr == ADDR_MASK) begin
				rdata_next = {29'h00000000, mask_reg};
			end else if (reg_addr == ADDR_INFO) begin
				rdata_next = {16'h0000, CFG_LEN, CFG_INST}; // [R03]
			end else if (reg_addr == ADDR_LED) begin
				rdata_next = {24'h000000, led_byte};
			end else begin
				rdata_next = 32'h00000000;
			end
		end
		irq_next = |(status_next & mask_next);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE; // [R10]
			in_inst_reg <= IN_INST_TABLES; // [R10]
			out_inst_reg <= OUT_INST_TABLES; // [R10]
			status_reg <= STATUS_RST;
			mask_reg <= MASK_RST;
			rdata_reg <= 32'h00000000;
			irq_reg <= 1'b0;
			rx_cnt_reg <= 6'h00;
			rx_shadow_reg <= 128'h0;
			tbl_reg <= 8'h00;
			seg_reg <= 8'h00;
			vin_reg <= 128'h0;
			active_reg <= 1'b0;
			img_reg <= 256'h0;
			tx_cnt_reg <= 6'h00;
			tx_len_reg <= LEN_SHORT;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			tx_last_reg <= 1'b0;
			treq_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			in_inst_reg <= in_inst_next;
			out_inst_reg <= out_inst_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_shadow_reg <= rx_shadow_next;
			tbl_reg <= tbl_next;
			seg_reg <= seg_next;
			vin_reg <= vin_next;
			active_reg <= active_next;
			img_reg <= img_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_len_reg <= tx_len_next;
			tx_valid_reg <= tx_valid_next;
			tx_data_reg <= tx_data_next;
			tx_last_reg <= tx_last_next;
			treq_reg <= treq_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq = irq_reg;
	assign tx_valid = tx_valid_reg;
	assign tx_data = tx_data_reg;
	assign tx_last = tx_last_reg;
	assign virtual_input_n = vin_reg;
	assign table_req = treq_reg;
	assign table_num = tbl_reg;
	assign segment_num = seg_reg;
endmodule // process_image_mapper
`default_nettype wire

// [testbench/image_map_sva.sv]
// port assertions for the process image mapper
`timescale 1ns/10ps
`default_nettype none
module image_map_sva (
	input wire logic         sys_clk,
	input wire logic         rst_n,
	input wire logic         reg_rd,
	input wire logic [31:0]  reg_rdata,
	input wire logic         irq,
	input wire logic         rx_valid,
	input wire logic [7:0]   rx_data,
	input wire logic         rx_last,
	input wire logic         tx_valid,
	input wire logic [7:0]   tx_data,
	input wire logic         tx_last,
	input wire logic         table_req,
	input wire logic [7:0]   table_num,
	input wire logic [7:0]   segment_num,
	input wire logic         table_ack,
	input wire logic [119:0] table_segment
);
	logic [5:0]   tx_idx_reg, tx_idx_next, rx_idx_reg, rx_idx_next;
	logic [15:0]  num_reg, num_next;
	logic [119:0] seg_reg, seg_next;
	// byte counters let the checks know the position in a burst
	always_comb begin
		tx_idx_next = (tx_valid && !tx_last) ? tx_idx_reg + 6'h1 : 6'h0;
		rx_idx_next = rx_idx_reg;
		if (rx_valid)
			rx_idx_next = rx_last ? 6'h0 : rx_idx_reg + 6'h1;
		num_next = num_reg;
		if (rx_valid && rx_idx_reg == 6'h10)
			num_next[15:8] = rx_data;
		if (rx_valid && rx_idx_reg == 6'h11)
			num_next[7:0] = rx_data;
		seg_next = table_ack ? table_segment : seg_reg;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tx_idx_reg <= 6'h0;
			rx_idx_reg <= 6'h0;
			num_reg <= 16'h0;
			seg_reg <= 120'h0;
		end else begin
			tx_idx_reg <= tx_idx_next;
			rx_idx_reg <= rx_idx_next;
			num_reg <= num_next;
			seg_reg <= seg_next;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	reply_len_a: assert property (tx_last |-> tx_valid &&
		(tx_idx_reg == 6'h10 || tx_idx_reg == 6'h1f))
		else $error("bad reply length");
	burst_hold_a: assert property (tx_valid && !tx_last |=> tx_valid)
		else $error("reply burst broken");
	burst_end_a: assert property (tx_last |=> !tx_valid)
		else $error("reply runs past last byte");
	req_pulse_a: assert property (table_req |=> !table_req)
		else $error("table request too long");
	req_nums_a: assert property (table_req |->
		{table_num, segment_num} == num_reg)
		else $error("table or segment number wrong");
	ack_reply_a: assert property (table_ack |-> ##2 $rose(tx_valid))
		else $error("reply late after segment");
	seg_bytes_a: assert property (tx_valid && tx_idx_reg > 6'h10 |->
		tx_data == seg_reg[8*(tx_idx_reg-6'h11) +: 8])
		else $error("segment byte wrong");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	reset_idle_a: assert property ($rose(rst_n) |->
		!tx_valid && !table_req && !irq)
		else $error("outputs busy after reset");
	cover property (tx_last && tx_idx_reg == 6'h10);
	cover property (tx_last && tx_idx_reg == 6'h1f);
	cover property (table_req);
endmodule // image_map_sva
`default_nettype wire

// [testbench/scanner_model.sv]
// fieldbus master model: sends frames, gathers reply bytes
`timescale 1ns/10ps
`default_nettype none
module scanner_model (
	input  wire logic       sys_clk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last
);
	logic [7:0] reply_q[$];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h0;
		rx_last = 1'b0;
	end
	// caller flushes the queue before each frame
	always @(posedge sys_clk) begin
		if (tx_valid)
			reply_q.push_back(tx_data);
	end
	// length other than 17 or 32 only when a refusal is wanted
	task automatic send_frame(input int len, input logic [255:0] img);
		for (int k = 0; k < len; k++) begin
			@(posedge sys_clk);
			rx_valid <= 1'b1;
			rx_data <= img[8*k +: 8];
			rx_last <= (k == len - 1);
		end
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		// idle line shows the inverse so no stale byte looks valid
		rx_data <= ~img[8*(len-1) +: 8];
		rx_last <= 1'b0;
	endtask
endmodule // scanner_model
`default_nettype wire

// [testbench/process_image_mapper_test.sv]
// self-checking bench for the process image mapper
`timescale 1ns/10ps
`default_nettype none
module process_image_mapper_test;
	import image_map_pkg::*;
	logic         sys_clk, rst_n, reg_wr, reg_rd, irq, rx_valid, rx_last;
	logic         tx_valid, tx_last, table_req, table_ack;
	logic [7:0]   reg_addr, rx_data, tx_data, table_num, segment_num;
	logic [31:0]  reg_wdata, reg_rdata;
	logic [127:0] virtual_input_n, virtual_output_n;
	logic [119:0] table_segment;
	logic [5:0]   ind;
	int           bad_count, check_count;
	localparam logic [127:0] IMG1 = 128'h0123456789abcdeffedcba9876543210;
	localparam logic [127:0] IMG2 = 128'h5a5a3c3c0ff0c3a5a55a96691e2d4b78;
	localparam logic [119:0] SEG1 = 120'h0f1e2d3c4b5a69788796a5b4c3d2e1;
	process_image_mapper u_process_image_mapper (
		.output_fault_indicator (ind[0]),
		.input_fault_indicator  (ind[1]),
		.fault_indicator        (ind[2]),
		.diagnostic_indicator   (ind[3]),
		.failsafe_run_indicator (ind[4]),
		.standard_run_indicator (ind[5]),
		.*
	);
	scanner_model u_scanner_model (.*);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// bounded wait, then a few idle cycles to catch extra bytes
	task automatic get_reply(input int n);
		for (int i = 0; i < 80 && u_scanner_model.reply_q.size() < n; i++)
			@(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		chk(u_scanner_model.reply_q.size(), n);
	endtask
	function automatic logic [7:0] led(input logic [5:0] i, input logic ex);
		return {1'b0, i[5], ex, i[4:0]};
	endfunction
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd_chk(ADDR_CTRL, 32'h9664);
		rd_chk(ADDR_INFO, 32'h0004);
		rd_chk(8'h20, 32'h0);
		wr(ADDR_CTRL, 32'h1234);
		rd_chk(ADDR_CTRL, 32'h9664);
		rd_chk(ADDR_LED, {24'h0, led(ind, 1'b0)});
	endtask
	task automatic t_long();
		wr(ADDR_MASK, 32'h2);
		u_scanner_model.reply_q.delete();
		u_scanner_model.send_frame(32, {112'h0, 8'h03, 8'h07, IMG1});
		// the request stands only in the cycle after the last byte
		#1 chk(table_req, 1'b1);
		chk({table_num, segment_num}, 16'h0703);
		chk(virtual_input_n, IMG1);
		@(posedge sys_clk);
		#1 chk(table_req, 1'b0);
		// base unit answers slowly
		repeat (5) @(posedge sys_clk);
		table_ack <= 1'b1;
		table_segment <= SEG1;
		@(posedge sys_clk);
		table_ack <= 1'b0;
		table_segment <= ~SEG1;
		get_reply(32);
		for (int k = 0; k < 16; k++)
			chk(u_scanner_model.reply_q[k], virtual_output_n[8*k +: 8]);
		chk(u_scanner_model.reply_q[16], led(6'h15, 1'b0));
		for (int k = 0; k < 15; k++)
			chk(u_scanner_model.reply_q[17+k], SEG1[8*k +: 8]);
		chk(irq, 1'b0);
		rd_chk(ADDR_STATUS, 32'h5);
	endtask
	task automatic t_short();
		wr(ADDR_CTRL, 32'h9765);
		wr(ADDR_STATUS, 32'h7);
		ind <= 6'h2a;
		virtual_output_n <= ~IMG2;
		u_scanner_model.reply_q.delete();
		u_scanner_model.send_frame(17, {120'h0, 8'hee, IMG2});
		#1 chk(table_req, 1'b0);
		get_reply(17);
		chk(virtual_input_n, IMG2);
		for (int k = 0; k < 16; k++)
			chk(u_scanner_model.reply_q[k], virtual_output_n[8*k +: 8]);
		chk(u_scanner_model.reply_q[16], led(6'h2a, 1'b1));
		rd_chk(ADDR_STATUS, 32'h1);
	endtask
	// 32 bytes is refused as well while the short instance is chosen
	task automatic t_bad();
		for (int n = 16; n <= 32; n += 16) begin
			u_scanner_model.reply_q.delete();
			u_scanner_model.send_frame(n, {256{1'b1}});
			get_reply(0);
			chk(virtual_input_n, IMG2);
		end
		chk(irq, 1'b1);
		// bit 0 still stands from the accepted short frame
		rd_chk(ADDR_STATUS, 32'h3);
		rd_chk(ADDR_LED, {24'h0, led(6'h2a, 1'b0)});
		wr(ADDR_STATUS, 32'h2);
		#1 chk(irq, 1'b0);
		rd_chk(ADDR_STATUS, 32'h1);
	endtask
	// mixed instances: long reply resends the held segment, short one none
	task automatic t_mixed();
		wr(ADDR_CTRL, 32'h9665);
		u_scanner_model.reply_q.delete();
		u_scanner_model.send_frame(17, {120'h0, 8'h00, ~IMG1});
		#1 chk(table_req, 1'b0);
		get_reply(32);
		chk(virtual_input_n, ~IMG1);
		for (int k = 0; k < 15; k++)
			chk(u_scanner_model.reply_q[17+k], SEG1[8*k +: 8]);
		wr(ADDR_CTRL, 32'h9764);
		u_scanner_model.reply_q.delete();
		u_scanner_model.send_frame(32, {112'h0, 8'h01, 8'h02, IMG1});
		#1 chk(table_req, 1'b0);
		get_reply(17);
		chk(virtual_input_n, IMG1);
		chk(u_scanner_model.reply_q[16], led(6'h2a, 1'b1));
	endtask
	// reset in mid-run brings back the power-up instances by itself
	task automatic t_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1 chk(virtual_input_n, 128'h0);
		chk(irq, 1'b0);
		rd_chk(ADDR_CTRL, 32'h9664);
		rd_chk(ADDR_LED, {24'h0, led(6'h2a, 1'b0)});
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{table_ack, table_segment} = '0;
		ind = 6'h15;
		virtual_output_n = IMG1 ^ IMG2;
		bad_count = 0;
		check_count = 0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_long();
		t_short();
		t_bad();
		t_mixed();
		t_reset();
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		print_verdict();
	end
endmodule // process_image_mapper_test
bind process_image_mapper image_map_sva u_image_map_sva (.*);
`default_nettype wire
